/* File: fsc_pkg.sv */
/*
 * Constants and types for the host-side flash status and continuity controller.
 * Assumes a 100 MHz system clock and an asynchronous NOR flash bus on the far side.
 */
package fsc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WE_PULSE_NS = 50;
    localparam int T_READ_NS = 100;
    localparam int T_RECOVER_NS = 30;
    localparam logic [7:0] T_WE_CYC = 8'((T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] T_READ_CYC = 8'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] T_RECOVER_CYC = 8'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // User command codes
    // ****************************************
    localparam logic [2:0] CMD_STATUS = 3'h0;
    localparam logic [2:0] CMD_CLEAR = 3'h1;
    localparam logic [2:0] CMD_CONT = 3'h2;
    localparam logic [2:0] CMD_SOFT_RESET = 3'h3;
    localparam logic [2:0] CMD_ERS_SUSPEND = 3'h4;
    localparam logic [2:0] CMD_ERS_RESUME = 3'h5;
    localparam logic [2:0] CMD_PRG_SUSPEND = 3'h6;
    localparam logic [2:0] CMD_PRG_RESUME = 3'h7;

    // ****************************************
    // Flash bus commands and addresses
    // ****************************************
    localparam logic [15:0] FL_STATUS_READ = 16'h0070;
    localparam logic [15:0] FL_STATUS_CLEAR = 16'h0071;
    localparam logic [15:0] FL_SOFT_RESET = 16'h00F0;
    localparam logic [15:0] FL_ERS_SUSPEND = 16'h00B0;
    localparam logic [15:0] FL_ERS_RESUME = 16'h0030;
    localparam logic [15:0] FL_PRG_SUSPEND = 16'h0051;
    localparam logic [15:0] FL_PRG_RESUME = 16'h0050;
    localparam logic [15:0] PAT1_X16 = 16'hFF00;
    localparam logic [15:0] PAT2_X16 = 16'h00FF;
    localparam logic [15:0] PAT1_X8 = 16'h00FF;
    localparam logic [15:0] PAT2_X8 = 16'h0000;
    localparam logic [26:0] AD_UNLOCK = 27'h0000555;
    localparam logic [26:0] AD_UNLOCK_X8 = 27'h0000AAA;
    localparam logic [26:0] AD_PAT1_X16 = 27'h2AAAA55;
    localparam logic [26:0] AD_PAT2_X16 = 27'h15555AA;
    localparam logic [26:0] AD_PAT1_X8 = 27'h55554AB;
    localparam logic [26:0] AD_PAT2_X8 = 27'h2AAAB54;
    localparam logic [26:0] AD_CMD_BASE = 27'h0000000;

    // ****************************************
    // Status word layout and sequence steps
    // ****************************************
    localparam int BIT_READY = 7;
    localparam int BIT_CONT = 0;
    localparam logic [2:0] STEP_CONT_PRE = 3'h2;
    localparam logic [2:0] STEP_CONT_POST = 3'h6;

    typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_DONE} fsc_op_t;

    typedef struct packed {
        fsc_op_t op;
        logic [26:0] addr;
        logic [15:0] data;
    } fsc_step_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_RLO, ST_RHI, ST_RECOV, ST_FINISH
    } fsc_state_t;

endpackage : fsc_pkg

/* File: fsc_host_ctrl.sv */
/*
 * Host controller that drives a NOR flash over its asynchronous pins to read and
 * clear status, run suspend, resume and soft reset, and run the continuity check.
 * Assumes the flash data pins are resolved outside from flashDqOut and flashDqOe,
 * and that flashDqIn is synchronous to sys_clk.
 */
// Notes on behaviour
// - x16 check: clear, status read expect 0, FF00/00FF patterns, status read expect 1.
// - x8 check: status at AAA, FF at 55554AB, 00 at 2AAAB54, status at 555.
// - flashDieSel, latched from dieSel, picks which stacked die sees the pattern writes.
// - Byte mode reads both status bytes by toggling A-1 under held strobes.
// - Bits 6 to 1 are meaningless while busy; host disregards them.
// - Bits 15 to 8 are don't-care; host masks them on every read.
// - After a suspend the host polls status until the ready bit is 1.
`timescale 1ns/100ps
module fsc_host_ctrl
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // User command port
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic byteMode,
    input wire logic dieSel,
    output logic cmdReady,
    output logic cmdDone,
    output logic [15:0] statusWord,
    output logic contPass,
    output logic contFail,
    // Flash bus
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic [25:0] flashAddr,
    output logic flashAddrLsb,
    output logic flashDieSel,
    output logic [15:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [15:0] flashDqIn
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        fsc_pkg::fsc_state_t st;
        logic [2:0] step;
        logic [2:0] cmd;
        logic byteMd;
        logic [7:0] cnt;
        logic ceN;
        logic oeN;
        logic weN;
        logic [25:0] addr;
        logic addrLsb;
        logic die;
        logic [15:0] dqOut;
        logic dqOe;
        logic [15:0] status;
        logic done;
        logic ready;
        logic contPass;
        logic contFail;
        logic checkBad;
    } fsc_regs_t;

    fsc_regs_t r_r;
    fsc_regs_t r_nxt;

    // ****************************************
    // Sequence table
    // ****************************************
    function automatic fsc_pkg::fsc_step_t stepOf(input logic [2:0] cmd, input logic [2:0] idx,
                                                  input logic x8);
        fsc_pkg::fsc_step_t s;
        logic [26:0] stAddr;
        s = '{op: fsc_pkg::OP_DONE, addr: fsc_pkg::AD_CMD_BASE, data: 16'h0000};
        stAddr = x8 ? fsc_pkg::AD_UNLOCK_X8 : fsc_pkg::AD_UNLOCK;
        case (cmd)
            fsc_pkg::CMD_STATUS:
            begin
                case (idx)
                    3'h0: s = '{fsc_pkg::OP_WRITE, stAddr, fsc_pkg::FL_STATUS_READ};
                    3'h1: s.op = fsc_pkg::OP_READ;
                    default: s.op = fsc_pkg::OP_DONE;
                endcase
            end
            fsc_pkg::CMD_CLEAR:
                if (idx == 3'h0) s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_UNLOCK, fsc_pkg::FL_STATUS_CLEAR};
            fsc_pkg::CMD_SOFT_RESET:
                if (idx == 3'h0) s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_CMD_BASE, fsc_pkg::FL_SOFT_RESET};
            fsc_pkg::CMD_ERS_RESUME:
                if (idx == 3'h0) s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_CMD_BASE, fsc_pkg::FL_ERS_RESUME};
            fsc_pkg::CMD_PRG_RESUME:
                if (idx == 3'h0) s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_CMD_BASE, fsc_pkg::FL_PRG_RESUME};
            fsc_pkg::CMD_ERS_SUSPEND, fsc_pkg::CMD_PRG_SUSPEND:
            begin
                case (idx)
                    3'h0: s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_CMD_BASE,
                                (cmd == fsc_pkg::CMD_ERS_SUSPEND) ? fsc_pkg::FL_ERS_SUSPEND
                                                                  : fsc_pkg::FL_PRG_SUSPEND};
                    3'h1: s = '{fsc_pkg::OP_WRITE, stAddr, fsc_pkg::FL_STATUS_READ};
                    3'h2: s.op = fsc_pkg::OP_READ;
                    default: s.op = fsc_pkg::OP_DONE;
                endcase
            end
            fsc_pkg::CMD_CONT:
            begin
                case (idx)
                    3'h0: s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_UNLOCK, fsc_pkg::FL_STATUS_CLEAR};
                    3'h1: s = '{fsc_pkg::OP_WRITE, stAddr, fsc_pkg::FL_STATUS_READ};
                    3'h2: s.op = fsc_pkg::OP_READ;
                    3'h3: s = '{fsc_pkg::OP_WRITE, x8 ? fsc_pkg::AD_PAT1_X8 : fsc_pkg::AD_PAT1_X16,
                                x8 ? fsc_pkg::PAT1_X8 : fsc_pkg::PAT1_X16};
                    3'h4: s = '{fsc_pkg::OP_WRITE, x8 ? fsc_pkg::AD_PAT2_X8 : fsc_pkg::AD_PAT2_X16,
                                x8 ? fsc_pkg::PAT2_X8 : fsc_pkg::PAT2_X16};
                    3'h5: s = '{fsc_pkg::OP_WRITE, fsc_pkg::AD_UNLOCK, fsc_pkg::FL_STATUS_READ};
                    3'h6: s.op = fsc_pkg::OP_READ;
                    default: s.op = fsc_pkg::OP_DONE;
                endcase
            end
            default: s.op = fsc_pkg::OP_DONE;
        endcase
        return s;
    endfunction : stepOf

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        fsc_pkg::fsc_step_t s;
        logic [15:0] word;
        logic isSusp;
        s = stepOf(r_r.cmd, r_r.step, r_r.byteMd);
        word = r_r.byteMd ? {flashDqIn[7:0], r_r.status[7:0]} : flashDqIn;
        isSusp = (r_r.cmd == fsc_pkg::CMD_ERS_SUSPEND) || (r_r.cmd == fsc_pkg::CMD_PRG_SUSPEND);
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        case (r_r.st)
            fsc_pkg::ST_IDLE:
            begin
                if (cmdValid && r_r.ready)
                begin
                    r_nxt.cmd = cmdCode;
                    r_nxt.byteMd = byteMode;
                    r_nxt.die = dieSel;
                    r_nxt.step = 3'h0;
                    r_nxt.ready = 1'b0;
                    r_nxt.checkBad = 1'b0;
                    r_nxt.st = fsc_pkg::ST_FETCH;
                end
            end
            fsc_pkg::ST_FETCH:
            begin
                r_nxt.addr = r_r.byteMd ? s.addr[26:1] : s.addr[25:0];
                r_nxt.addrLsb = r_r.byteMd ? s.addr[0] : 1'b0;
                case (s.op)
                    fsc_pkg::OP_WRITE:
                    begin
                        r_nxt.dqOut = s.data;
                        r_nxt.dqOe = 1'b1;
                        r_nxt.ceN = 1'b0;
                        r_nxt.st = fsc_pkg::ST_WSETUP;
                    end
                    fsc_pkg::OP_READ:
                    begin
                        r_nxt.addrLsb = 1'b0;
                        r_nxt.ceN = 1'b0;
                        r_nxt.oeN = 1'b0;
                        r_nxt.cnt = fsc_pkg::T_READ_CYC - 8'h01;
                        r_nxt.st = fsc_pkg::ST_RLO;
                    end
                    default: r_nxt.st = fsc_pkg::ST_FINISH;
                endcase
            end
            fsc_pkg::ST_WSETUP:
            begin
                r_nxt.weN = 1'b0;
                r_nxt.cnt = fsc_pkg::T_WE_CYC - 8'h01;
                r_nxt.st = fsc_pkg::ST_WPULSE;
            end
            fsc_pkg::ST_WPULSE:
            begin
                r_nxt.cnt = r_r.cnt - 8'h01;
                if (r_r.cnt == 8'h00)
                begin
                    r_nxt.weN = 1'b1;
                    r_nxt.st = fsc_pkg::ST_WHOLD;
                end
            end
            fsc_pkg::ST_WHOLD:
            begin
                r_nxt.ceN = 1'b1;
                r_nxt.dqOe = 1'b0;
                r_nxt.step = r_r.step + 3'h1;
                r_nxt.cnt = fsc_pkg::T_RECOVER_CYC - 8'h01;
                r_nxt.st = fsc_pkg::ST_RECOV;
            end
            fsc_pkg::ST_RLO, fsc_pkg::ST_RHI:
            begin
                r_nxt.cnt = r_r.cnt - 8'h01;
                if (r_r.cnt == 8'h00)
                begin
                    if (r_r.byteMd && r_r.st == fsc_pkg::ST_RLO)
                    begin
                        // Strobes held low so one overlay entry yields both bytes
                        r_nxt.status[7:0] = flashDqIn[fsc_pkg::BIT_READY] ? flashDqIn[7:0]
                                            : {7'h00, flashDqIn[fsc_pkg::BIT_CONT]};
                        r_nxt.addrLsb = 1'b1;
                        r_nxt.cnt = fsc_pkg::T_READ_CYC - 8'h01;
                        r_nxt.st = fsc_pkg::ST_RHI;
                    end
                    else
                    begin
                        if (!r_r.byteMd)
                            word = flashDqIn;
                        // Upper byte is noise; busy hides the result bits
                        r_nxt.status = {8'h00, word[fsc_pkg::BIT_READY],
                                        word[fsc_pkg::BIT_READY] ? word[6:1] : 6'h00,
                                        word[fsc_pkg::BIT_CONT]};
                        if (r_r.cmd == fsc_pkg::CMD_CONT &&
                            ((r_r.step == fsc_pkg::STEP_CONT_PRE && word[fsc_pkg::BIT_CONT]) ||
                             (r_r.step == fsc_pkg::STEP_CONT_POST && !word[fsc_pkg::BIT_CONT])))
                            r_nxt.checkBad = 1'b1;
                        // Keep polling until the suspend has taken hold
                        if (isSusp && !word[fsc_pkg::BIT_READY])
                            r_nxt.step = r_r.step - 3'h1;
                        else
                            r_nxt.step = r_r.step + 3'h1;
                        r_nxt.ceN = 1'b1;
                        r_nxt.oeN = 1'b1;
                        r_nxt.cnt = fsc_pkg::T_RECOVER_CYC - 8'h01;
                        r_nxt.st = fsc_pkg::ST_RECOV;
                    end
                end
            end
            fsc_pkg::ST_RECOV:
            begin
                r_nxt.cnt = r_r.cnt - 8'h01;
                if (r_r.cnt == 8'h00)
                    r_nxt.st = fsc_pkg::ST_FETCH;
            end
            fsc_pkg::ST_FINISH:
            begin
                r_nxt.done = 1'b1;
                r_nxt.ready = 1'b1;
                if (r_r.cmd == fsc_pkg::CMD_CONT)
                begin
                    r_nxt.contPass = !r_r.checkBad;
                    r_nxt.contFail = r_r.checkBad;
                end
                r_nxt.st = fsc_pkg::ST_IDLE;
            end
            default: r_nxt.st = fsc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_r <= '0;
            r_r.ceN <= 1'b1;
            r_r.oeN <= 1'b1;
            r_r.weN <= 1'b1;
            r_r.ready <= 1'b1;
        end
        else if (clkEn)
            r_r <= r_nxt;
    end

    assign cmdReady = r_r.ready;
    assign cmdDone = r_r.done;
    assign statusWord = r_r.status;
    assign contPass = r_r.contPass;
    assign contFail = r_r.contFail;
    assign flashCeN = r_r.ceN;
    assign flashOeN = r_r.oeN;
    assign flashWeN = r_r.weN;
    assign flashAddr = r_r.addr;
    assign flashAddrLsb = r_r.addrLsb;
    assign flashDieSel = r_r.die;
    assign flashDqOut = r_r.dqOut;
    assign flashDqOe = r_r.dqOe;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_upper_masked: assert property (statusWord[15:8] == 8'h00)
        else $error("upper status byte not masked");
    chk_busy_hidden: assert property (!statusWord[7] |-> statusWord[6:1] == 6'h00)
        else $error("result bits shown while busy");
    chk_die_stable: assert property (!cmdReady && !$fell(cmdReady) |-> $stable(flashDieSel))
        else $error("die select moved mid command");
    chk_we_drive_data: assert property (!flashWeN |-> flashDqOe && !flashCeN && flashOeN)
        else $error("write strobe without driven data");
    chk_we_width: assert property ($fell(flashWeN) |-> !flashWeN [*5])
        else $error("write pulse too short");
    chk_byte_pair: assert property ($rose(flashAddrLsb) && !flashOeN
                                    |-> $past(!flashOeN) && $past(!flashCeN))
        else $error("byte toggle outside held strobes");
    chk_poll_ready: assert property (cmdDone && (r_r.cmd == fsc_pkg::CMD_ERS_SUSPEND ||
                                     r_r.cmd == fsc_pkg::CMD_PRG_SUSPEND) |-> statusWord[7])
        else $error("suspend finished before ready");

    cov_cont_pass: cover property (cmdDone && contPass);
    cov_cont_fail: cover property (cmdDone && contFail);
    cov_byte_read: cover property ($rose(flashAddrLsb) && !flashOeN);
    cov_poll_loop: cover property (r_r.st == fsc_pkg::ST_RLO ##[1:60] r_r.st == fsc_pkg::ST_WSETUP);

endmodule : fsc_host_ctrl

/* File: fsc_flash_model.sv */
/*
 * Behavioural model of one flash die: status word, status overlay and pattern compare.
 * Assumes the host strobes change on clk edges, so the model watches them on clk.
 */
`timescale 1ns/100ps
module fsc_flash_model
(
    // Clock and cold reset
    input wire logic clk,
    input wire logic rst,
    // Die setup
    input wire logic dieId,
    input wire logic byteMode,
    input wire logic brokenPin,
    // Flash pins
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [25:0] addr,
    input wire logic addrLsb,
    input wire logic dieSel,
    input wire logic [15:0] dqIn,
    output logic drvEn,
    output logic [15:0] drvData
);
    // ****************
    // State
    // ****************
    logic [6:0] stat; // Result bits kept as set
    logic [15:0] snap;
    logic overlay;
    logic [7:0] busyReads;
    logic [7:0] junk;
    logic [26:0] prevAddr;
    logic [15:0] prevData;
    logic prevWeN;
    logic prevRd;
    logic hit;
    logic rdNow;
    logic [26:0] wAddr;
    logic [15:0] wData;

    assign hit = (dieSel == dieId);
    assign rdNow = hit && !ceN && !oeN;
    assign drvEn = rdNow;
    // Byte lane follows A-1 while strobes stay low
    assign drvData = !overlay ? 16'h0000 : !byteMode ? snap :
        {8'h00, addrLsb ? snap[15:8] : snap[7:0]};
    // A broken pin reads low, which spoils the inverse pattern
    assign wAddr = (byteMode ? {addr, addrLsb} : {1'b0, addr}) & ~{21'h0, brokenPin, 5'h00};
    assign wData = byteMode ? {8'h00, dqIn[7:0]} : dqIn;

    // ****************
    // Bus cycles
    // ****************
    task automatic preset(input logic [7:0] v);
        stat = v[6:0];
        busyReads = v[7] ? 8'h00 : 8'hFF;
    endtask : preset

    task automatic write_cycle();
        prevAddr <= wAddr;
        prevData <= wData;
        if (overlay && wData[7:0] != 8'hF0)
            junk <= junk; // Writes other than F0 ignored in overlay
        else
            case (wData[7:0])
                8'hF0:
                begin
                    overlay <= 1'b0;
                    if (!stat[3])
                        stat <= stat & 7'h4C;
                end
                8'h71: stat <= stat & 7'h44;
                8'h70:
                begin
                    snap <= {junk, busyReads == 8'h00, stat};
                    junk <= junk + 8'h5B; // Reserved byte changes with each status read command
                    overlay <= 1'b1;
                end
                8'hB0:
                begin
                    stat[6] <= 1'b1;
                    busyReads <= 8'h02;
                end
                8'h30: stat[6] <= 1'b0;
                8'h51:
                begin
                    stat[2] <= 1'b1;
                    busyReads <= 8'h02;
                end
                8'h50: stat[2] <= 1'b0;
                default:
                    if (byteMode ? (prevAddr == 27'h55554AB && prevData[7:0] == 8'hFF &&
                            wAddr == ~prevAddr && wData[7:0] == 8'h00) :
                            (prevAddr == 27'h2AAAA55 && prevData == 16'hFF00 &&
                            wAddr == {1'b0, ~prevAddr[25:0]} && wData == 16'h00FF))
                        stat[0] <= 1'b1; // Programs change nothing here
            endcase
    endtask : write_cycle

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stat <= 7'h00;
            snap <= 16'h0000;
            overlay <= 1'b0;
            busyReads <= 8'h00;
            junk <= 8'h3C;
            prevAddr <= 27'h0;
            prevData <= 16'h0000;
            prevWeN <= 1'b1;
            prevRd <= 1'b0;
        end
        else
        begin
            prevWeN <= weN;
            prevRd <= rdNow;
            if (prevRd && !rdNow && overlay)
            begin
                overlay <= 1'b0;
                if (busyReads != 8'h00)
                    busyReads <= busyReads - 8'h01;
            end
            if (hit && !ceN && weN && !prevWeN)
                write_cycle();
        end
    end
endmodule : fsc_flash_model

/* File: fsc_host_ctrl_test.sv */
/*
 * Self-checking bench for the host flash status controller with two model dies.
 * Assumes the design package is compiled first and the dies share the data bus.
 */
`timescale 1ns/100ps
module fsc_host_ctrl_test;
    typedef struct packed {
        logic [7:0] pre;
        logic [2:0] code;
        logic bm;
        logic [15:0] exp;
    } fsc_row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic cmdValid = 1'b0;
    logic [2:0] cmdCode = 3'h0;
    logic byteMode = 1'b0;
    logic dieSel = 1'b0;
    logic brokenPin = 1'b0;
    logic cmdReady, cmdDone, contPass, contFail, flashCeN, flashOeN, flashWeN;
    logic flashAddrLsb, flashDieSel, flashDqOe, en0, en1;
    logic [15:0] statusWord, flashDqOut, flashDqIn, d0, d1, devData;
    logic [15:0] lastBus = 16'h0000;
    logic [25:0] flashAddr;
    int errCount = 0;
    int checksDone = 0;
    fsc_row_t rows[10] = '{
        '{8'hFF, 3'h0, 1'b0, 16'h00FF}, '{8'hFF, 3'h0, 1'b1, 16'h00FF},
        '{8'hFF, 3'h1, 1'b0, 16'h00C4}, '{8'hFF, 3'h3, 1'b1, 16'h00FF},
        '{8'hF7, 3'h3, 1'b0, 16'h00C4}, '{8'h7F, 3'h0, 1'b0, 16'h0001},
        '{8'h80, 3'h4, 1'b0, 16'h00C0}, '{8'hC0, 3'h5, 1'b0, 16'h0080},
        '{8'h80, 3'h6, 1'b1, 16'h0084}, '{8'h84, 3'h7, 1'b0, 16'h0080}};

    always #5 sys_clk = ~sys_clk;

    // ****************
    // Bus wiring
    // ****************
    // Released lines show the inverse of their last value, so stale data never matches
    assign devData = en0 ? d0 : d1;
    assign flashDqIn[7:0] = flashDqOe ? flashDqOut[7:0] : (en0 | en1) ? devData[7:0] : ~lastBus[7:0];
    assign flashDqIn[15:8] = flashDqOe ? flashDqOut[15:8] :
        ((en0 | en1) && !byteMode) ? devData[15:8] : ~lastBus[15:8];
    always @(posedge sys_clk)
        lastBus <= flashDqIn;

    fsc_host_ctrl dut_u (.sys_clk, .sys_rst, .clkEn, .cmdValid, .cmdCode, .byteMode, .dieSel,
        .cmdReady, .cmdDone, .statusWord, .contPass, .contFail, .flashCeN, .flashOeN, .flashWeN,
        .flashAddr, .flashAddrLsb, .flashDieSel, .flashDqOut, .flashDqOe, .flashDqIn);
    fsc_flash_model u_die0 (.clk(sys_clk), .rst(sys_rst), .dieId(1'b0), .byteMode, .brokenPin,
        .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr), .addrLsb(flashAddrLsb),
        .dieSel(flashDieSel), .dqIn(flashDqIn), .drvEn(en0), .drvData(d0));
    fsc_flash_model u_die1 (.clk(sys_clk), .rst(sys_rst), .dieId(1'b1), .byteMode, .brokenPin,
        .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr), .addrLsb(flashAddrLsb),
        .dieSel(flashDieSel), .dqIn(flashDqIn), .drvEn(en1), .drvData(d1));

    // ****************
    // Tasks
    // ****************
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic got, input logic exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic run_cmd(input logic [2:0] code, input logic bm, input logic ds);
        int n;
        n = 0;
        cmdCode <= code;
        byteMode <= bm;
        dieSel <= ds;
        cmdValid <= 1'b1;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (cmdDone !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            errCount++;
            conclude();
        end
    endtask : run_cmd

    task automatic check_cont(input logic bm, input logic ds, input logic good);
        run_cmd(3'h2, bm, ds);
        cmp_flag(contPass, good);
        cmp_flag(contFail, !good);
    endtask : check_cont

    // ****************
    // Sequence
    // ****************
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        cmp_word(statusWord, 16'h0000);
        cmp_flag(cmdReady, 1'b1);
        for (int i = 0; i < 10; i++)
        begin
            u_die0.preset(rows[i].pre);
            run_cmd(rows[i].code, rows[i].bm, 1'b0);
            run_cmd(3'h0, rows[i].bm, 1'b0);
            cmp_word(statusWord, rows[i].exp);
        end
        check_cont(1'b0, 1'b0, 1'b1);
        check_cont(1'b1, 1'b0, 1'b1);
        u_die0.preset(8'h80);
        check_cont(1'b0, 1'b1, 1'b1);
        cmp_flag(u_die0.stat[0], 1'b0);
        brokenPin <= 1'b1;
        check_cont(1'b0, 1'b0, 1'b0);
        brokenPin <= 1'b0;
        // Frozen enable must stretch the write strobe and lose no step
        cmdCode <= 3'h1;
        cmdValid <= 1'b1;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        clkEn <= 1'b0;
        repeat (12) @(posedge sys_clk);
        cmp_flag(flashWeN, 1'b0);
        clkEn <= 1'b1;
        for (int n = 0; n < 200 && cmdDone !== 1'b1; n++)
            @(posedge sys_clk);
        cmp_flag(cmdDone, 1'b1);
        u_die0.preset(8'hFF);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        cmp_flag(contPass, 1'b0);
        run_cmd(3'h0, 1'b0, 1'b0);
        cmp_word(statusWord, 16'h0080);
        conclude();
    end
endmodule : fsc_host_ctrl_test
